// ===== gpipm_pkg.sv
package gpipm_pkg;
    localparam int NPORT = 2;
    localparam int PW = 32;
    localparam int NPIN = 64;
    localparam int NSLOT = 8;
    localparam int NGRP = 2;
    // register action codes, used for writes and reads
    localparam logic [2:0] ACT_DATA = 3'h0;
    localparam logic [2:0] ACT_MASKED = 3'h1;
    localparam logic [2:0] ACT_SET = 3'h2;
    localparam logic [2:0] ACT_CLR = 3'h3;
    localparam logic [2:0] ACT_TOG = 3'h4;
    localparam logic [2:0] ACT_DIR = 3'h5;
    localparam logic [2:0] ACT_MASK = 3'h6;
    localparam logic [2:0] ACT_PIN = 3'h7;
    // reset values
    localparam logic [PW-1:0] OUT_RST = 32'h0000_0000;
    localparam logic [PW-1:0] DIR_RST = 32'h0000_0000;
    localparam logic [PW-1:0] MASK_RST = 32'h0000_0000;
    // pattern slice conditions
    localparam logic [2:0] PM_ONE = 3'h0;
    localparam logic [2:0] PM_ST_RISE = 3'h1;
    localparam logic [2:0] PM_ST_FALL = 3'h2;
    localparam logic [2:0] PM_ST_EDGE = 3'h3;
    localparam logic [2:0] PM_HIGH = 3'h4;
    localparam logic [2:0] PM_LOW = 3'h5;
    localparam logic [2:0] PM_ZERO = 3'h6;
    localparam logic [2:0] PM_EV_EDGE = 3'h7;
    // power modes
    localparam logic [1:0] PWR_ACTIVE = 2'h0;
    localparam logic [1:0] PWR_SLEEP = 2'h1;
    localparam logic [1:0] PWR_DEEP = 2'h2;
    localparam logic [1:0] PWR_DOWN = 2'h3;
endpackage

// ===== gpipm_pint_if.sv
`timescale 1ns/1ps
interface gpipm_pint_if;
    logic [7:0] lvl;
    logic [7:0] irq;
    logic match;
    modport src(output lvl, input irq, match);
    modport eng(input lvl, output irq, match);
endinterface

// ===== gpipm_pint.sv
`timescale 1ns/1ps
module gpipm_pint
    import gpipm_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // selected pin levels and requests
    gpipm_pint_if.eng bus,
    // pin interrupt config
    input wire logic [7:0] level_mode_in,
    input wire logic [7:0] level_low_in,
    input wire logic [7:0] rise_en_in,
    input wire logic [7:0] fall_en_in,
    input wire logic [7:0] edge_clr_in,
    // pattern engine config
    input wire logic pm_en_in,
    input wire logic [7:0][2:0] pm_src_in,
    input wire logic [7:0][2:0] pm_cond_in,
    input wire logic [7:0] pm_endpt_in
);
    logic [7:0] prev_r;
    logic [7:0] flag_r;
    logic [7:0] st_r;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] pint_req;
    logic [7:0] slice_ok;
    logic [7:0] term;
    logic run;

    assign rise = bus.lvl & ~prev_r;
    assign fall = ~bus.lvl & prev_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_r <= 8'h00;
        end else begin
            prev_r <= bus.lvl;
        end
    end

    // sticky edge flags, set wins over clear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_r <= 8'h00;
        end else begin
            flag_r <= (flag_r & ~edge_clr_in) | (rise & rise_en_in) | (fall & fall_en_in);
        end
    end

    assign pint_req = (level_mode_in & (bus.lvl ^ level_low_in)) | (~level_mode_in & flag_r);

    // pattern slices
    always_comb begin
        for (int i = 0; i < NSLOT; i++) begin
            case (pm_cond_in[i])
                PM_ONE: slice_ok[i] = 1'b1;
                PM_ST_RISE, PM_ST_FALL, PM_ST_EDGE: slice_ok[i] = st_r[i];
                PM_HIGH: slice_ok[i] = bus.lvl[pm_src_in[i]];
                PM_LOW: slice_ok[i] = ~bus.lvl[pm_src_in[i]];
                PM_EV_EDGE: slice_ok[i] = rise[pm_src_in[i]] | fall[pm_src_in[i]];
                default: slice_ok[i] = 1'b0;
            endcase
        end
    end

    // product terms end at endpoint slices
    always_comb begin
        run = 1'b1;
        term = 8'h00;
        for (int i = 0; i < NSLOT; i++) begin
            run = run & slice_ok[i];
            if (pm_endpt_in[i]) begin
                term[i] = run;
                run = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= 8'h00;
        end else begin
            for (int i = 0; i < NSLOT; i++) begin
                if (!pm_en_in || (|term)) begin
                    st_r[i] <= 1'b0;
                end else if ((pm_cond_in[i] == PM_ST_RISE && rise[pm_src_in[i]])
                             || (pm_cond_in[i] == PM_ST_FALL && fall[pm_src_in[i]])
                             || (pm_cond_in[i] == PM_ST_EDGE && (rise[pm_src_in[i]] | fall[pm_src_in[i]]))) begin
                    st_r[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus.irq <= 8'h00;
            bus.match <= 1'b0;
        end else begin
            bus.irq <= pm_en_in ? term : pint_req;
            bus.match <= pm_en_in & (|term);
        end
    end
endmodule

// ===== gpipm_top.sv
`timescale 1ns/1ps
// Function
// - two 32-bit ports, 64 pins, each pin gpio unless a peripheral or the event routing owns it
// - pin read returns synchronised pad level whatever function owns the pin
// - per-pin direction bit, all pins inputs after reset
// - set, clear, toggle change only bits written as one
// - mask register protects masked bits in masked reads and writes
// - byte, halfword and word writes via byte enables; word writes whole port
// - eight selectable pins, each with its own interrupt request
// - edge mode fires on rising, falling or both edges
// - level mode active high or low, request held while level active
// - pattern engine evaluates product terms over levels and transitions
// - each product term raises its own interrupt request
// - any match optionally pulses cpu event, routable to a pin
// - two group interrupts from programmed pin combinations
// - group wakes from sleep, deep-sleep, power-down; pin irq sleep, deep-sleep
// - pattern engine wakes only in active and sleep modes
module gpipm_top
    import gpipm_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // pads
    input wire logic [NPIN-1:0] pad_in_in,
    output logic [NPIN-1:0] pad_out_out,
    output logic [NPIN-1:0] pad_oe_out,
    // peripheral function routing
    input wire logic [NPIN-1:0] periph_own_in,
    input wire logic [NPIN-1:0] periph_out_in,
    input wire logic [NPIN-1:0] periph_oe_in,
    // register write port
    input wire logic wr_en_in,
    input wire logic [2:0] wr_act_in,
    input wire logic wr_port_in,
    input wire logic [3:0] wr_be_in,
    input wire logic [PW-1:0] wr_data_in,
    // register read port
    input wire logic rd_en_in,
    input wire logic [2:0] rd_act_in,
    input wire logic rd_port_in,
    output logic [PW-1:0] rd_data_out,
    output logic rd_valid_out,
    // pin interrupt config
    input wire logic [7:0][5:0] pint_sel_in,
    input wire logic [7:0] pint_level_mode_in,
    input wire logic [7:0] pint_level_low_in,
    input wire logic [7:0] pint_rise_en_in,
    input wire logic [7:0] pint_fall_en_in,
    input wire logic [7:0] pint_edge_clr_in,
    // pattern engine config
    input wire logic pm_en_in,
    input wire logic [7:0][2:0] pm_src_in,
    input wire logic [7:0][2:0] pm_cond_in,
    input wire logic [7:0] pm_endpt_in,
    input wire logic pm_ev_en_in,
    input wire logic ev_pin_en_in,
    input wire logic [5:0] ev_pin_sel_in,
    // group interrupt config
    input wire logic [NGRP-1:0][NPIN-1:0] grp_ena_in,
    input wire logic [NGRP-1:0][NPIN-1:0] grp_pol_in,
    input wire logic [NGRP-1:0] grp_and_in,
    // power mode
    input wire logic [1:0] pwr_mode_in,
    // requests
    output logic [7:0] pint_irq_out,
    output logic cpu_event_out,
    output logic [NGRP-1:0] grp_irq_out,
    output logic wake_out
);
    logic [NPIN-1:0] pad_s1_r;
    logic [NPIN-1:0] pad_s2_r;
    logic [NPORT-1:0][PW-1:0] out_r;
    logic [NPORT-1:0][PW-1:0] dir_r;
    logic [NPORT-1:0][PW-1:0] mask_r;
    logic [PW-1:0] bm;
    logic [PW-1:0] wd;
    logic [PW-1:0] pin_port;
    logic match_d_r;
    logic [NPIN-1:0] gpio_out;
    logic [NPIN-1:0] gpio_oe;
    logic [NPIN-1:0] ev_hit;
    logic [NGRP-1:0] grp_hit;

    gpipm_pint_if pint_bus();

    function automatic logic [PW-1:0] be_bits(input logic [3:0] be);
        logic [PW-1:0] r;
        r = '0;
        for (int b = 0; b < 4; b++) begin
            r[b*8 +: 8] = {8{be[b]}};
        end
        return r;
    endfunction

    function automatic logic [PW-1:0] merge(input logic [PW-1:0] old, input logic [PW-1:0] d,
                                            input logic [PW-1:0] en);
        return (old & ~en) | (d & en);
    endfunction

    // pad synchroniser
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pad_s1_r <= 64'h0000_0000_0000_0000;
            pad_s2_r <= 64'h0000_0000_0000_0000;
        end else begin
            pad_s1_r <= pad_in_in;
            pad_s2_r <= pad_s1_r;
        end
    end

    assign bm = be_bits(wr_be_in);
    assign wd = wr_data_in & bm;

    // output data register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_r <= {NPORT{OUT_RST}};
        end else if (wr_en_in) begin
            case (wr_act_in)
                ACT_DATA: out_r[wr_port_in] <= merge(out_r[wr_port_in], wr_data_in, bm);
                ACT_MASKED: out_r[wr_port_in] <= merge(out_r[wr_port_in], wr_data_in,
                                                       bm & ~mask_r[wr_port_in]);
                ACT_SET: out_r[wr_port_in] <= out_r[wr_port_in] | wd;
                ACT_CLR: out_r[wr_port_in] <= out_r[wr_port_in] & ~wd;
                ACT_TOG: out_r[wr_port_in] <= out_r[wr_port_in] ^ wd;
                default: out_r <= out_r;
            endcase
        end
    end

    // direction, one means output
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_r <= {NPORT{DIR_RST}};
        end else if (wr_en_in && wr_act_in == ACT_DIR) begin
            dir_r[wr_port_in] <= merge(dir_r[wr_port_in], wr_data_in, bm);
        end
    end

    // mask, one protects the bit
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_r <= {NPORT{MASK_RST}};
        end else if (wr_en_in && wr_act_in == ACT_MASK) begin
            mask_r[wr_port_in] <= merge(mask_r[wr_port_in], wr_data_in, bm);
        end
    end

    assign pin_port = rd_port_in ? pad_s2_r[2*PW-1:PW] : pad_s2_r[PW-1:0];

    // register reads
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 32'h0000_0000;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_en_in;
            if (rd_en_in) begin
                case (rd_act_in)
                    ACT_PIN: rd_data_out <= pin_port;
                    ACT_MASKED: rd_data_out <= pin_port & ~mask_r[rd_port_in];
                    ACT_DATA, ACT_SET, ACT_CLR, ACT_TOG: rd_data_out <= out_r[rd_port_in];
                    ACT_DIR: rd_data_out <= dir_r[rd_port_in];
                    ACT_MASK: rd_data_out <= mask_r[rd_port_in];
                    default: rd_data_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // pin selection into the interrupt and pattern unit
    always_comb begin
        for (int i = 0; i < NSLOT; i++) begin
            pint_bus.lvl[i] = pad_s2_r[pint_sel_in[i]];
        end
    end

    gpipm_pint i_gpipm_pint (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .bus(pint_bus.eng),
        .level_mode_in(pint_level_mode_in),
        .level_low_in(pint_level_low_in),
        .rise_en_in(pint_rise_en_in),
        .fall_en_in(pint_fall_en_in),
        .edge_clr_in(pint_edge_clr_in),
        .pm_en_in(pm_en_in),
        .pm_src_in(pm_src_in),
        .pm_cond_in(pm_cond_in),
        .pm_endpt_in(pm_endpt_in)
    );

    assign gpio_out = {out_r[1], out_r[0]};
    assign gpio_oe = {dir_r[1], dir_r[0]};
    assign ev_hit = ev_pin_en_in ? (64'h0000_0000_0000_0001 << ev_pin_sel_in) : 64'h0000_0000_0000_0000;

    // pad drive, peripheral wins, then event routing, then gpio
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pad_out_out <= 64'h0000_0000_0000_0000;
            pad_oe_out <= 64'h0000_0000_0000_0000;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (periph_own_in[i]) begin
                    pad_out_out[i] <= periph_out_in[i];
                    pad_oe_out[i] <= periph_oe_in[i];
                end else if (ev_hit[i]) begin
                    pad_out_out[i] <= cpu_event_out;
                    pad_oe_out[i] <= 1'b1;
                end else begin
                    pad_out_out[i] <= gpio_out[i];
                    pad_oe_out[i] <= gpio_oe[i];
                end
            end
        end
    end

    // group combinations
    always_comb begin
        for (int g = 0; g < NGRP; g++) begin
            if (grp_and_in[g]) begin
                grp_hit[g] = (|grp_ena_in[g]) && (&(~grp_ena_in[g] | (pad_s2_r ^ grp_pol_in[g])));
            end else begin
                grp_hit[g] = |(grp_ena_in[g] & (pad_s2_r ^ grp_pol_in[g]));
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pint_irq_out <= 8'h00;
            grp_irq_out <= 2'h0;
            match_d_r <= 1'b0;
            cpu_event_out <= 1'b0;
        end else begin
            pint_irq_out <= pint_bus.irq;
            grp_irq_out <= grp_hit;
            match_d_r <= pint_bus.match;
            cpu_event_out <= pm_ev_en_in & pint_bus.match & ~match_d_r;
        end
    end

    // wake-up qualified by power mode
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_out <= 1'b0;
        end else begin
            case (pwr_mode_in)
                PWR_ACTIVE, PWR_SLEEP: wake_out <= (|grp_irq_out) | (|pint_irq_out);
                PWR_DEEP: wake_out <= (|grp_irq_out) | (~pm_en_in & (|pint_irq_out));
                PWR_DOWN: wake_out <= |grp_irq_out;
                default: wake_out <= 1'b0;
            endcase
        end
    end
endmodule

// ===== gpipm_pad_model.sv
`timescale 1ns/1ps
module gpipm_pad_model
    import gpipm_pkg::*;
(
    // design side
    input wire logic [NPIN-1:0] pad_out_in,
    input wire logic [NPIN-1:0] pad_oe_in,
    // external drivers
    input wire logic [NPIN-1:0] ext_val_in,
    input wire logic [NPIN-1:0] ext_drv_in,
    // resolved pad level
    output logic [NPIN-1:0] pad_lvl_out
);
    // undriven pads fall to the pull-down
    assign pad_lvl_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_drv_in & ext_val_in);
endmodule

// ===== gpipm_checker.sv
`timescale 1ns/1ps
module gpipm_checker
    import gpipm_pkg::*;
(
    // watched ports
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [NPIN-1:0] pad_in_in,
    input wire logic [NPIN-1:0] pad_out_out,
    input wire logic [NPIN-1:0] pad_oe_out,
    input wire logic [NPIN-1:0] periph_own_in,
    input wire logic wr_en_in,
    input wire logic [2:0] wr_act_in,
    input wire logic wr_port_in,
    input wire logic [3:0] wr_be_in,
    input wire logic [PW-1:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [2:0] rd_act_in,
    input wire logic rd_port_in,
    input wire logic [PW-1:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic ev_pin_en_in,
    input wire logic [NGRP-1:0][NPIN-1:0] grp_ena_in,
    input wire logic [NGRP-1:0][NPIN-1:0] grp_pol_in,
    input wire logic [NGRP-1:0] grp_and_in,
    input wire logic [1:0] pwr_mode_in,
    input wire logic cpu_event_out,
    input wire logic [NGRP-1:0] grp_irq_out,
    input wire logic wake_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic wr0;
    logic own0;
    assign wr0 = wr_en_in && !wr_port_in && wr_be_in == 4'hF;
    assign own0 = periph_own_in[31:0] == 32'h0 && !ev_pin_en_in;
    sequence s_grp_calm;
        ($stable(pad_in_in) && $stable(grp_ena_in) && $stable(grp_pol_in) && $stable(grp_and_in)) [*4];
    endsequence
    AST_RST_INPUTS: assert property ($rose(rst_n_in) |-> pad_oe_out == 64'h0)
        else $error("pins not inputs after reset");
    AST_WORD_WRITE: assert property (wr0 && own0 && wr_act_in == ACT_DATA ##1 !wr_en_in && own0
        |=> pad_out_out[31:0] == $past(wr_data_in, 2)) else $error("word write not on pads");
    AST_DIR_DRIVES: assert property (wr0 && own0 && wr_act_in == ACT_DIR ##1 !wr_en_in && own0
        |=> pad_oe_out[31:0] == $past(wr_data_in, 2)) else $error("direction not on enables");
    AST_RD_ANSWER: assert property (rd_en_in |=> rd_valid_out)
        else $error("read not answered");
    AST_RD_IDLE: assert property (!rd_en_in |=> !rd_valid_out)
        else $error("valid without read");
    AST_PIN_LEVEL: assert property ($stable(pad_in_in[63:32]) [*3] ##0 rd_en_in && rd_act_in == ACT_PIN
        && rd_port_in |=> rd_data_out == $past(pad_in_in[63:32])) else $error("pin read wrong");
    AST_GRP_ANY: assert property (s_grp_calm ##0 !grp_and_in[0] && grp_pol_in[0] == 64'h0
        && (pad_in_in & grp_ena_in[0]) != 64'h0 |=> grp_irq_out[0]) else $error("group missed");
    AST_GRP_NONE: assert property (s_grp_calm ##0 !grp_and_in[0] && grp_pol_in[0] == 64'h0
        && (pad_in_in & grp_ena_in[0]) == 64'h0 |=> !grp_irq_out[0]) else $error("group spurious");
    AST_EVENT_PULSE: assert property (cpu_event_out |=> !cpu_event_out)
        else $error("event longer than a pulse");
    AST_WAKE_DOWN: assert property ((pwr_mode_in == PWR_DOWN && grp_irq_out == 2'h0) [*3] |=> !wake_out)
        else $error("wake in power-down without group");
    AST_GRP_WAKES: assert property ((pwr_mode_in == PWR_DOWN && grp_irq_out[0]) [*2] |=> wake_out)
        else $error("group did not wake");
    cover property (rd_en_in && rd_act_in == ACT_PIN);
    cover property (cpu_event_out);
    cover property (wake_out && pwr_mode_in == PWR_DOWN);
endmodule
bind gpipm_top gpipm_checker i_gpipm_checker (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .pad_in_in(pad_in_in), .pad_out_out(pad_out_out),
    .pad_oe_out(pad_oe_out), .periph_own_in(periph_own_in), .wr_en_in(wr_en_in), .wr_act_in(wr_act_in),
    .wr_port_in(wr_port_in), .wr_be_in(wr_be_in), .wr_data_in(wr_data_in), .rd_en_in(rd_en_in),
    .rd_act_in(rd_act_in), .rd_port_in(rd_port_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .ev_pin_en_in(ev_pin_en_in), .grp_ena_in(grp_ena_in), .grp_pol_in(grp_pol_in), .grp_and_in(grp_and_in),
    .pwr_mode_in(pwr_mode_in), .cpu_event_out(cpu_event_out), .grp_irq_out(grp_irq_out), .wake_out(wake_out)
);

// ===== tb_gpio_pin_interrupt_pattern.sv
`timescale 1ns/1ps
module tb_gpio_pin_interrupt_pattern;
    import gpipm_pkg::*;
    logic clk_in, rst_n_in, wr_en_in, wr_port_in, rd_en_in, rd_port_in, rd_valid_out;
    logic pm_en_in, pm_ev_en_in, ev_pin_en_in, cpu_event_out, wake_out;
    logic [2:0] wr_act_in, rd_act_in;
    logic [3:0] wr_be_in;
    logic [PW-1:0] wr_data_in, rd_data_out;
    logic [NPIN-1:0] pad_in_in, pad_out_out, pad_oe_out, periph_own_in, periph_out_in, periph_oe_in;
    logic [NPIN-1:0] ext_val, ext_drv;
    logic [7:0][5:0] pint_sel_in;
    logic [7:0] pint_level_mode_in, pint_level_low_in, pint_rise_en_in, pint_fall_en_in;
    logic [7:0] pint_edge_clr_in, pm_endpt_in, pint_irq_out;
    logic [7:0][2:0] pm_src_in, pm_cond_in;
    logic [5:0] ev_pin_sel_in;
    logic [NGRP-1:0][NPIN-1:0] grp_ena_in, grp_pol_in;
    logic [NGRP-1:0] grp_and_in, grp_irq_out;
    logic [1:0] pwr_mode_in;
    logic [11:0] probe;
    int num_errors, tests_run;
    assign probe = {wake_out, cpu_event_out, grp_irq_out, pint_irq_out};
    gpipm_top i_gpipm_top (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .pad_in_in(pad_in_in), .pad_out_out(pad_out_out),
        .pad_oe_out(pad_oe_out), .periph_own_in(periph_own_in), .periph_out_in(periph_out_in),
        .periph_oe_in(periph_oe_in), .wr_en_in(wr_en_in), .wr_act_in(wr_act_in), .wr_port_in(wr_port_in),
        .wr_be_in(wr_be_in), .wr_data_in(wr_data_in), .rd_en_in(rd_en_in), .rd_act_in(rd_act_in),
        .rd_port_in(rd_port_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .pint_sel_in(pint_sel_in), .pint_level_mode_in(pint_level_mode_in), .pint_level_low_in(pint_level_low_in),
        .pint_rise_en_in(pint_rise_en_in), .pint_fall_en_in(pint_fall_en_in), .pint_edge_clr_in(pint_edge_clr_in),
        .pm_en_in(pm_en_in), .pm_src_in(pm_src_in), .pm_cond_in(pm_cond_in), .pm_endpt_in(pm_endpt_in),
        .pm_ev_en_in(pm_ev_en_in), .ev_pin_en_in(ev_pin_en_in), .ev_pin_sel_in(ev_pin_sel_in),
        .grp_ena_in(grp_ena_in), .grp_pol_in(grp_pol_in), .grp_and_in(grp_and_in), .pwr_mode_in(pwr_mode_in),
        .pint_irq_out(pint_irq_out), .cpu_event_out(cpu_event_out), .grp_irq_out(grp_irq_out), .wake_out(wake_out)
    );
    gpipm_pad_model i_gpipm_pad_model (
        .pad_out_in(pad_out_out), .pad_oe_in(pad_oe_out), .ext_val_in(ext_val), .ext_drv_in(ext_drv),
        .pad_lvl_out(pad_in_in)
    );
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic wr(input logic [2:0] act, input logic port, input logic [3:0] be, input logic [31:0] d);
        @(negedge clk_in);
        {wr_en_in, wr_act_in, wr_port_in, wr_be_in, wr_data_in} = {1'b1, act, port, be, d};
        @(negedge clk_in);
        wr_en_in = 1'b0;
    endtask
    task automatic rd(input logic [2:0] act, input logic port, input logic [31:0] exp, input string msg);
        @(negedge clk_in);
        {rd_en_in, rd_act_in, rd_port_in} = {1'b1, act, port};
        @(negedge clk_in);
        rd_en_in = 1'b0;
        chk(rd_valid_out, 1'b1, "read valid");
        if (rd_valid_out !== 1'b1) begin
            end_of_test();
        end
        chk(rd_data_out, exp, msg);
    endtask
    task automatic wait_probe(input int b, input logic v, input string msg);
        int i;
        i = 0;
        while (probe[b] !== v && i < 20) begin
            @(negedge clk_in);
            i++;
        end
        chk(probe[b], v, msg);
        if (probe[b] !== v) begin
            end_of_test();
        end
    endtask
    task automatic clr2;
        pint_edge_clr_in[2] = 1'b1;
        ticks(1);
        pint_edge_clr_in[2] = 1'b0;
    endtask
    task automatic t_reset;
        chk(pad_oe_out, 64'h0, "oe after reset");
        rd(ACT_DIR, 1'b0, DIR_RST, "dir0 reset");
        rd(ACT_DIR, 1'b1, DIR_RST, "dir1 reset");
        wr(ACT_PIN, 1'b0, 4'hF, 32'hFFFF_FFFF);
        rd(ACT_DATA, 1'b0, OUT_RST, "pin view is read only");
        $display("test reset done");
    endtask
    task automatic t_bits;
        wr(ACT_DIR, 1'b0, 4'hF, 32'hFFFF_FFFF);
        wr(ACT_DATA, 1'b0, 4'hF, 32'h1234_5678);
        wr(ACT_SET, 1'b0, 4'hF, 32'h0000_00F0);
        rd(ACT_DATA, 1'b0, 32'h1234_56F8, "set");
        wr(ACT_CLR, 1'b0, 4'hF, 32'h0000_0F00);
        rd(ACT_CLR, 1'b0, 32'h1234_50F8, "clear readback");
        wr(ACT_TOG, 1'b0, 4'hF, 32'hFF00_0000);
        rd(ACT_TOG, 1'b0, 32'hED34_50F8, "toggle readback");
        wr(ACT_DATA, 1'b0, 4'h2, 32'hAAAA_AAAA);
        wr(ACT_DATA, 1'b0, 4'hC, 32'h5555_0000);
        rd(ACT_SET, 1'b0, 32'h5555_AAF8, "byte and halfword");
        chk(pad_oe_out[31:0], 32'hFFFF_FFFF, "dir out");
        chk(pad_out_out[31:0], 32'h5555_AAF8, "pad drive");
        $display("test set clear toggle done");
    endtask
    task automatic t_mask;
        ext_drv[63:32] = 32'hFFFF_FFFF;
        ext_val[63:32] = 32'hA5A5_5A5A;
        wr(ACT_MASK, 1'b1, 4'hF, 32'hFFFF_0000);
        wr(ACT_MASKED, 1'b1, 4'hF, 32'hFFFF_FFFF);
        rd(ACT_DATA, 1'b1, 32'h0000_FFFF, "masked write");
        rd(ACT_MASKED, 1'b1, 32'h0000_5A5A, "masked read");
        rd(ACT_PIN, 1'b1, 32'hA5A5_5A5A, "pin read");
        rd(ACT_MASK, 1'b1, 32'hFFFF_0000, "mask");
        wr(ACT_MASK, 1'b1, 4'hF, 32'h0000_0000);
        $display("test mask done");
    endtask
    task automatic t_periph;
        ext_drv[47:40] = 8'h00;
        periph_out_in[47:40] = 8'h3C;
        periph_oe_in[47:40] = 8'hFF;
        periph_own_in[47:40] = 8'hFF;
        ticks(5);
        chk(pad_oe_out[47:40], 8'hFF, "peripheral drives");
        rd(ACT_PIN, 1'b1, 32'hA5A5_3C5A, "pin under peripheral");
        periph_own_in = 64'h0;
        ext_drv[47:40] = 8'hFF;
        $display("test peripheral pins done");
    endtask
    task automatic t_pint;
        logic [1:0] m;
        pint_sel_in[2] = 6'h23;
        for (int k = 1; k < 4; k++) begin
            m = k[1:0];
            {pint_rise_en_in[2], pint_fall_en_in[2]} = m;
            ext_val[35] = 1'b1;
            ticks(8);
            clr2();
            ext_val[35] = 1'b0;
            ticks(8);
            chk(pint_irq_out, {5'h0, m[0], 2'h0}, "falling edge");
            clr2();
            ext_val[35] = 1'b1;
            ticks(8);
            chk(pint_irq_out, {5'h0, m[1], 2'h0}, "rising edge");
        end
        {pint_rise_en_in[2], pint_fall_en_in[2]} = 2'h0;
        clr2();
        pint_level_mode_in[2] = 1'b1;
        for (int k = 0; k < 2; k++) begin
            pint_level_low_in[2] = k[0];
            ticks(8);
            chk(pint_irq_out, {5'h0, ~k[0], 2'h0}, "level pin high");
            ext_val[35] = 1'b0;
            ticks(8);
            chk(pint_irq_out, {5'h0, k[0], 2'h0}, "level pin low");
            ext_val[35] = 1'b1;
        end
        pint_level_low_in[2] = 1'b0;
        $display("test pin interrupt done");
    endtask
    task automatic t_group;
        grp_ena_in[0] = 64'h0000_0030_0000_0000;
        grp_ena_in[1] = 64'h0000_0030_0000_0000;
        grp_pol_in[1] = 64'h0000_0010_0000_0000;
        grp_and_in = 2'h2;
        ticks(6);
        chk(grp_irq_out, 2'h1, "or of one pin");
        ext_val[37:36] = 2'h2;
        ticks(6);
        chk(grp_irq_out, 2'h3, "and with low polarity");
        pwr_mode_in = PWR_DOWN;
        ticks(3);
        chk(wake_out, 1'b1, "group wakes power-down");
        ext_val[37:36] = 2'h0;
        ticks(6);
        chk(grp_irq_out, 2'h0, "no group active");
        chk(wake_out, 1'b0, "pin irq no wake in power-down");
        pwr_mode_in = PWR_DEEP;
        ticks(3);
        chk(wake_out, 1'b1, "pin irq wakes deep-sleep");
        pint_level_mode_in[2] = 1'b0;
        $display("test group done");
    endtask
    task automatic t_pattern;
        ext_val[35] = 1'b0;
        pm_src_in[0] = 3'h2;
        pm_cond_in[0] = PM_HIGH;
        pm_endpt_in = 8'h01;
        {pm_ev_en_in, ev_pin_en_in} = 2'h3;
        pm_en_in = 1'b1;
        ticks(6);
        ext_val[35] = 1'b1;
        wait_probe(10, 1'b1, "cpu event");
        wait_probe(0, 1'b1, "term request");
        ticks(1);
        chk(pad_out_out[0], 1'b1, "event pin");
        ticks(1);
        chk(wake_out, 1'b0, "no pattern wake in deep-sleep");
        pwr_mode_in = PWR_SLEEP;
        ticks(3);
        chk(wake_out, 1'b1, "pattern wakes sleep");
        $display("test pattern done");
    endtask
    initial begin
        {rst_n_in, wr_en_in, wr_port_in, rd_en_in, rd_port_in, pm_en_in, pm_ev_en_in, ev_pin_en_in} = 8'h0;
        {wr_act_in, rd_act_in, wr_be_in, wr_data_in, ev_pin_sel_in, pwr_mode_in} = 50'h0;
        {periph_own_in, periph_out_in, periph_oe_in, ext_val, ext_drv} = 320'h0;
        {pint_level_mode_in, pint_level_low_in, pint_rise_en_in, pint_fall_en_in} = 32'h0;
        {pint_edge_clr_in, pm_endpt_in, pint_sel_in, pm_src_in, pm_cond_in} = 112'h0;
        {grp_ena_in, grp_pol_in, grp_and_in} = 258'h0;
        num_errors = 0;
        tests_run = 0;
        ticks(5);
        rst_n_in = 1'b1;
        t_reset();
        t_bits();
        t_mask();
        t_periph();
        t_pint();
        t_group();
        t_pattern();
        end_of_test();
    end
endmodule
